// *** common/prox_cfg_pkg.sv ***
package prox_cfg_pkg;
  // Register map
  localparam logic [7:0] EMIT_CUR_ADDR = 8'h83;
  localparam logic [7:0] AMB_PARAM_ADDR = 8'h84;
  // Emitter current register layout
  localparam int CUR_FIELD_MSB = 5;
  localparam int REV_LSB = 6;
  localparam logic [5:0] CUR_RESET = 6'h02;
  localparam logic [4:0] CUR_MAX_CODE = 5'h14;
  localparam int CUR_STEP_MA = 10;
  // Ambient parameter register layout
  localparam int CONT_BIT = 7;
  localparam int RATE_LSB = 4;
  localparam int OFFS_BIT = 3;
  localparam int AVG_LSB = 0;
  localparam logic [7:0] AMB_RESET = 8'h0d;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // Averaging sample and accumulator widths (128 x 16-bit samples)
  localparam int SAMPLE_W = 16;
  localparam int SUM_W = 23;

  typedef enum logic [2:0] {
    AVG_IDLE = 3'b001,
    AVG_OFFSET = 3'b010,
    AVG_CONV = 3'b100
  } avg_state_e;
endpackage

// *** hw/ambient_averager.sv ***
module ambient_averager
  import prox_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Control
  input wire logic start,
  input wire logic offset_en,
  input wire logic [2:0] avg_code,
  // Converter samples
  input wire logic sample_valid,
  input wire logic [prox_cfg_pkg::SAMPLE_W-1:0] sample_data,
  // Status and result
  output logic conv_busy,
  output logic offset_phase,
  output logic result_valid,
  output logic [prox_cfg_pkg::SAMPLE_W-1:0] result
);
  import prox_cfg_pkg::*;

  typedef struct packed {
    avg_state_e st;
    logic [7:0] cnt;
    logic [SUM_W-1:0] sum;
    logic [SAMPLE_W-1:0] offs;
    logic [SAMPLE_W-1:0] res;
    logic done;
    logic busy;
    logic offs_ph;
  } avg_s;

  avg_s state_ff;
  avg_s nxt_state;
  logic [7:0] last_cnt;
  logic [SUM_W-1:0] acc;
  logic [SAMPLE_W-1:0] mean;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.done = 1'b0;
    last_cnt = 8'((9'h001 << avg_code) - 9'h001);
    acc = state_ff.sum + SUM_W'(sample_data);
    mean = SAMPLE_W'(acc >> avg_code);
    unique case (state_ff.st)
      AVG_IDLE:
      begin
        if (start)
        begin
          nxt_state.cnt = 8'h00;
          nxt_state.sum = '0;
          nxt_state.offs = '0;
          // Dark offset is taken before each measurement when enabled
          nxt_state.st = offset_en ? AVG_OFFSET : AVG_CONV;
        end
      end
      AVG_OFFSET:
      begin
        if (sample_valid)
        begin
          nxt_state.offs = sample_data;
          nxt_state.st = AVG_CONV;
        end
      end
      AVG_CONV:
      begin
        if (sample_valid)
        begin
          nxt_state.sum = acc;
          nxt_state.cnt = state_ff.cnt + 8'h01;
          if (state_ff.cnt == last_cnt)
          begin
            // Clamp at zero so a noisy dark reading never wraps the result
            nxt_state.res = (mean > state_ff.offs) ? mean - state_ff.offs : '0;
            nxt_state.done = 1'b1;
            nxt_state.st = AVG_IDLE;
          end
        end
      end
      default: nxt_state.st = AVG_IDLE;
    endcase
    // Status kept as flops so the top-level outputs carry no decode logic
    nxt_state.busy = (nxt_state.st != AVG_IDLE);
    nxt_state.offs_ph = (nxt_state.st == AVG_OFFSET);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      state_ff <= '{st: AVG_IDLE, cnt: 8'h00, sum: '0, offs: '0, res: '0, done: 1'b0,
                    busy: 1'b0, offs_ph: 1'b0};
    else
      state_ff <= nxt_state;
  end

  assign conv_busy = state_ff.busy;
  assign offset_phase = state_ff.offs_ph;
  assign result_valid = state_ff.done;
  assign result = state_ff.res;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_start_offset;
    start && offset_en && state_ff.st == AVG_IDLE;
  endsequence

  sequence s_offset_taken;
    state_ff.st == AVG_OFFSET && sample_valid;
  endsequence

  a_offset_first: assert property (@(posedge clk) disable iff (!rstn)
    s_start_offset |=> state_ff.st == AVG_OFFSET)
    else $error("offset phase not entered at start");

  a_offset_then_conv: assert property (@(posedge clk) disable iff (!rstn)
    s_offset_taken |=> state_ff.st == AVG_CONV && state_ff.offs == $past(sample_data))
    else $error("offset sample not held before conversions");

  a_single_conv_done: assert property (@(posedge clk) disable iff (!rstn)
    (state_ff.st == AVG_CONV && avg_code == 3'h0 && sample_valid && state_ff.offs == '0)
      |=> result_valid && result == $past(sample_data))
    else $error("one-sample average wrong");

  a_count_bound: assert property (@(posedge clk) disable iff (!rstn)
    state_ff.st == AVG_CONV |-> {1'b0, state_ff.cnt} <= ((9'h001 << avg_code) - 9'h001))
    else $error("conversion count overran the averaging setting");
endmodule // ambient_averager

// *** hw/prox_led_and_ambient_config.sv ***
module prox_led_and_ambient_config
  import prox_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register access from the serial interface
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Fused calibration revision pins
  input wire logic [1:0] cal_rev_pins,
  // Sequencer side
  input wire logic single_ambient_request,
  input wire logic sample_valid,
  input wire logic [prox_cfg_pkg::SAMPLE_W-1:0] sample_data,
  // Emitter drive
  output logic [4:0] emitter_code,
  output logic [7:0] emitter_ma,
  // Ambient control and result
  output logic [2:0] ambient_rate_code,
  output logic ambient_busy,
  output logic ambient_offset_phase,
  output logic ambient_valid,
  output logic [prox_cfg_pkg::SAMPLE_W-1:0] ambient_result
);
  import prox_cfg_pkg::*;

  typedef struct packed {
    logic [5:0] cur;
    logic [7:0] amb;
    logic [1:0] rev_meta;
    logic [1:0] rev;
    logic [7:0] rdata;
    logic [4:0] code;
    logic [7:0] ma;
  } cfg_s;

  cfg_s state_ff;
  cfg_s nxt_state;
  logic meas_start;
  logic avg_busy;
  logic avg_offs;
  logic avg_done;
  logic [SAMPLE_W-1:0] avg_res;
  logic [4:0] clamped;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.rev_meta = cal_rev_pins;
    nxt_state.rev = state_ff.rev_meta;
    if (reg_wr && reg_addr == EMIT_CUR_ADDR)
      nxt_state.cur = reg_wdata[CUR_FIELD_MSB:0];
    // Changing this while a conversion runs is the host's job to avoid
    if (reg_wr && reg_addr == AMB_PARAM_ADDR)
      nxt_state.amb = reg_wdata;
    // Out-of-range codes saturate rather than wrap to a low current
    if (state_ff.cur > 6'(CUR_MAX_CODE))
      clamped = CUR_MAX_CODE;
    else
      clamped = state_ff.cur[4:0];
    nxt_state.code = clamped;
    nxt_state.ma = 8'(clamped) * 8'(CUR_STEP_MA);
    unique case (reg_addr)
      EMIT_CUR_ADDR: nxt_state.rdata = {state_ff.rev, state_ff.cur};
      AMB_PARAM_ADDR: nxt_state.rdata = state_ff.amb;
      default: nxt_state.rdata = UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      state_ff <= '{cur: CUR_RESET, amb: AMB_RESET, rev_meta: 2'h0, rev: 2'h0,
                    rdata: 8'h00, code: CUR_RESET[4:0],
                    ma: 8'(CUR_RESET) * 8'(CUR_STEP_MA)};
    else
      state_ff <= nxt_state;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Continuous mode restarts right after each result for back-to-back readings
  assign meas_start = !avg_busy &&
                      (single_ambient_request || (state_ff.amb[CONT_BIT] && avg_done));

  ambient_averager u_avg (
    .clk(clk),
    .rstn(rstn),
    .start(meas_start),
    .offset_en(state_ff.amb[OFFS_BIT]),
    .avg_code(state_ff.amb[AVG_LSB +: 3]),
    .sample_valid(sample_valid),
    .sample_data(sample_data),
    .conv_busy(avg_busy),
    .offset_phase(avg_offs),
    .result_valid(avg_done),
    .result(avg_res)
  );

  assign reg_rdata = state_ff.rdata;
  assign emitter_code = state_ff.code;
  assign emitter_ma = state_ff.ma;
  assign ambient_rate_code = state_ff.amb[RATE_LSB +: 3];
  assign ambient_busy = avg_busy;
  assign ambient_offset_phase = avg_offs;
  assign ambient_valid = avg_done;
  assign ambient_result = avg_res;

  ////////////////////////////////////////////////////////////////////////////
  a_drive_clamp: assert property (@(posedge clk) disable iff (!rstn)
    emitter_code <= CUR_MAX_CODE && emitter_ma <= 8'd200)
    else $error("emitter drive above cap");

  a_drive_step: assert property (@(posedge clk) disable iff (!rstn)
    emitter_ma == 8'(emitter_code) * 8'd10)
    else $error("emitter current not code times step");

  a_write_clamps: assert property (@(posedge clk) disable iff (!rstn)
    (reg_wr && reg_addr == EMIT_CUR_ADDR && reg_wdata[5:0] > 6'h14)
      |=> ##1 emitter_code == 5'h14)
    else $error("large code not clamped to twenty");

  a_rev_readonly: assert property (@(posedge clk) disable iff (!rstn)
    (reg_wr && reg_addr == EMIT_CUR_ADDR) ##1 (reg_addr == EMIT_CUR_ADDR)
      |=> reg_rdata[7:6] == $past(state_ff.rev_meta, 2) &&
          reg_rdata[5:0] == 6'($past(reg_wdata, 2)))
    else $error("revision bits disturbed by write");

  a_cont_restart: assert property (@(posedge clk) disable iff (!rstn)
    (avg_done && state_ff.amb[CONT_BIT]) |=> avg_busy)
    else $error("continuous mode did not restart");

  a_no_cont_stop: assert property (@(posedge clk) disable iff (!rstn)
    (avg_done && !state_ff.amb[CONT_BIT] && !single_ambient_request) |=> !avg_busy)
    else $error("conversion restarted without request");
endmodule // prox_led_and_ambient_config

// *** tb/sample_source.sv ***
module sample_source (
  // Clock and measurement state
  input wire logic clk,
  input wire logic busy,
  input wire logic offset_phase,
  // Scenario settings
  input wire logic [15:0] off_val,
  input wire logic [15:0] base,
  input wire logic [3:0] gap,
  // Converter samples
  output logic sample_valid,
  output logic [15:0] sample_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] cnt = 4'h0;
  logic [15:0] k = 16'h0;
  logic busy_q = 1'b0;
  initial sample_valid = 1'b0;
  initial sample_data = 16'h0;
  // Dark sample first, then a ramp of base + 2k; data toggles between samples so no stale value
  always @(posedge clk)
  begin
    busy_q <= busy;
    if (busy && !sample_valid && cnt >= gap)
    begin
      sample_valid <= #1 1'b1;
      sample_data <= #1 offset_phase ? off_val : base + (k << 1);
      k <= offset_phase ? k : k + 16'h1;
      cnt <= 4'h0;
    end
    else
    begin
      sample_valid <= #1 1'b0;
      sample_data <= #1 ~sample_data;
      cnt <= cnt + 4'h1;
      // Ramp survives the single idle cycle of a continuous restart
      if (!busy && !busy_q) k <= 16'h0;
    end
  end
endmodule // sample_source

// *** tb/tb.sv ***
module tb;
  import prox_cfg_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic req = 1'b0;
  logic sv;
  logic [15:0] sd;
  logic [15:0] off_val = 16'h0;
  logic [15:0] base = 16'h0;
  logic [3:0] gap = 4'h0;
  logic [4:0] emitter_code;
  logic [7:0] emitter_ma;
  logic [2:0] rate;
  logic busy;
  logic offs_ph;
  logic amb_valid;
  logic [15:0] amb_res;
  logic [15:0] last_res = 16'h0;
  logic [5:0] codes [5] = '{6'h00, 6'h01, 6'h14, 6'h15, 6'h3f};
  logic [5:0] ec;
  int n_valid = 0;
  int errors = 0;
  int n_tests = 0;
  always #5 clk = ~clk;
  prox_led_and_ambient_config i_dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cal_rev_pins(2'b10),
    .single_ambient_request(req), .sample_valid(sv), .sample_data(sd),
    .emitter_code(emitter_code), .emitter_ma(emitter_ma), .ambient_rate_code(rate),
    .ambient_busy(busy), .ambient_offset_phase(offs_ph), .ambient_valid(amb_valid),
    .ambient_result(amb_res));
  sample_source i_src (.clk(clk), .busy(busy), .offset_phase(offs_ph), .off_val(off_val),
    .base(base), .gap(gap), .sample_valid(sv), .sample_data(sd));
  // Results are latched here so a fast measurement cannot slip past a waiting task
  always @(posedge clk)
    if (amb_valid === 1'b1)
    begin
      last_res <= amb_res;
      n_valid <= n_valid + 1;
    end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1 reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    repeat (2) @(posedge clk);
    #1 chk({8'h00, reg_rdata}, {8'h00, e});
  endtask
  task automatic wv;
    int n0;
    int t;
    n0 = n_valid;
    t = 0;
    while (n_valid == n0 && t < 3000)
    begin
      @(posedge clk);
      t++;
    end
    #1 chk(16'(t < 3000), 16'h1);
  endtask
  task automatic pulse;
    req = 1'b1;
    @(posedge clk);
    #1 req = 0;
  endtask
  task automatic meas(input logic [7:0] c, input logic [15:0] o, input logic [15:0] b,
                      input logic [3:0] g, input logic [15:0] e);
    wr(AMB_PARAM_ADDR, c);
    off_val = o;
    base = b;
    gap = g;
    pulse();
    chk({15'h0, offs_ph}, {15'h0, c[OFFS_BIT]});
    // A second request while busy must not start another measurement
    @(posedge clk);
    #1 if (busy === 1'b1) pulse();
    wv();
    chk(last_res, e);
    repeat (2) @(posedge clk);
    #1 chk({15'h0, busy}, 16'h0);
  endtask
  task automatic results;
    $display("comparisons %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (4) @(posedge clk);
    #1 rd(EMIT_CUR_ADDR, {2'b10, CUR_RESET});
    rd(AMB_PARAM_ADDR, 8'h0d);
    chk({8'h00, emitter_ma}, 16'd20);
    rd(8'h90, 8'h00);
    $display("test reset values done");
    foreach (codes[i])
    begin
      wr(EMIT_CUR_ADDR, {2'b01, codes[i]});
      rd(EMIT_CUR_ADDR, {2'b10, codes[i]});
      ec = codes[i] > 6'h14 ? 6'h14 : codes[i];
      chk({11'h0, emitter_code}, {10'h0, ec});
      chk({8'h00, emitter_ma}, 16'(ec * 10));
    end
    wr(AMB_PARAM_ADDR, 8'h5a);
    rd(AMB_PARAM_ADDR, 8'h5a);
    chk({13'h0, rate}, 16'h5);
    $display("test registers done");
    for (int a = 0; a < 8; a++)
      meas(8'(a), 16'h0, 16'h0, 4'(a % 3), 16'((1 << a) - 1));
    meas(8'h09, 16'd5, 16'd100, 4'h0, 16'd96);
    meas(8'h08, 16'd200, 16'd100, 4'h1, 16'h0);
    $display("test measurements done");
    // Continuous mode started by a single request; the second result comes from its self-timed restart
    wr(AMB_PARAM_ADDR, 8'h80);
    base = 16'd50;
    gap = 4'h1;
    pulse();
    wv();
    chk(last_res, 16'd50);
    wv();
    chk(last_res, 16'd52);
    chk({15'h0, busy}, 16'h1);
    rstn = 1'b0;
    @(posedge clk);
    #1 rstn = 1'b1;
    repeat (4) @(posedge clk);
    #1 rd(AMB_PARAM_ADDR, 8'h0d);
    rd(EMIT_CUR_ADDR, {2'b10, CUR_RESET});
    $display("test continuous and second reset done");
    results();
  end
  initial
  begin
    #400000;
    chk(16'h1, 16'h0);
    results();
  end
endmodule // tb
